// File: design/iio_pkg.sv
/*
  Shared definitions for the inching and I/O override register block:
  word offsets, value codes, reset values and the carrier structs.
  Assumes a 16-bit parameter word access port, one word per offset.
*/
package iio_pkg;

  // parameter word offsets
  localparam logic [15:0] OFS_INCH_SPEED = 16'h040a;
  localparam logic [15:0] OFS_FORCE_OUT = 16'h040c;
  localparam logic [15:0] OFS_IN_STATUS = 16'h040e;
  localparam logic [15:0] OFS_KEY_CHECK = 16'h0410;
  localparam logic [15:0] OFS_OUT_STATUS = 16'h0412;
  localparam logic [15:0] OFS_CAL_SELECT = 16'h0414;

  // inching word codes
  localparam logic [15:0] INCH_STOP = 16'h0000;
  localparam logic [15:0] INCH_FWD_CODE = 16'h1386;
  localparam logic [15:0] INCH_REV_CODE = 16'h1387;
  localparam logic [15:0] INCH_SPEED_MAX = 16'h1388;
  localparam logic [15:0] INCH_SPEED_RST = 16'h0014;

  // value ranges
  localparam logic [15:0] FORCE_MAX = 16'h003f;
  localparam logic [15:0] SOFT_IN_MAX = 16'h01ff;
  localparam int N_IN = 9;
  localparam int N_OUT = 6;
  localparam int N_KEY = 5;
  localparam logic [3:0] TERM_NONE = 4'h0;

  // calibration selector codes
  localparam logic [2:0] CAL_SPEED = 3'h1;
  localparam logic [2:0] CAL_TORQUE = 3'h2;
  localparam logic [2:0] CAL_V_CUR = 3'h3;
  localparam logic [2:0] CAL_W_CUR = 3'h4;
  localparam logic [2:0] CAL_ALL4 = 3'h5;
  localparam logic [2:0] CAL_IGBT = 3'h6;
  localparam logic [15:0] CAL_MAX = 16'h0006;
  localparam int N_CAL = 5;

  // panel keys, bit 4 first
  typedef struct packed {
    logic set;
    logic shift;
    logic down;
    logic up;
    logic mode;
  } iio_key_s;

  // one parameter access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic from_panel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iio_acc_s;

endpackage

// File: design/iio_sync.sv
/*
  Two-flop synchroniser for a bus of independent levels.
  Assumes each bit is a slow level; no word coherence is given.
*/
module iio_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule

// File: design/iio_cal_seq.sv
/*
  Calibration sequencer: turns a selector code into start pulses for
  the offset adjustments, stepping through four for the combined code.
  Assumes the analog side answers each start with a one-cycle done.
*/
module iio_cal_seq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // request
  input wire logic start,
  input wire logic [2:0] code,
  // analog side
  input wire logic item_done,
  output logic [iio_pkg::N_CAL-1:0] item_start,
  output logic busy
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} iio_cal_e;

  localparam int N_CAL_LAST = iio_pkg::N_CAL - 1;

  iio_cal_e state_reg;
  logic [2:0] item_reg;
  logic all_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
      item_reg <= '0;
      all_reg <= 1'b0;
      item_start <= '0;
    end else begin
      item_start <= '0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            all_reg <= (code == iio_pkg::CAL_ALL4);
            item_reg <= (code == iio_pkg::CAL_ALL4) ?
                        iio_pkg::CAL_SPEED : code;
            state_reg <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          // igbt is item 4, the others map code-1
          if (item_reg == iio_pkg::CAL_IGBT) begin
            item_start[N_CAL_LAST] <= 1'b1;
          end else begin
            item_start[item_reg - 3'h1] <= 1'b1;
          end
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          if (item_done) begin
            if (all_reg && item_reg != iio_pkg::CAL_W_CUR) begin
              item_reg <= item_reg + 3'h1;
              state_reg <= S_ISSUE;
            end else begin
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  assign busy = (state_reg != S_IDLE);

endmodule

// File: design/iio_regs.sv
/*
  Inching control and I/O override parameter words of a servo drive:
  inching word, forced outputs, input source mix, key check, output
  status and calibration selector, on a 16-bit parameter access port.
  Assumes requests come one at a time from the panel or the link,
  panel keys and input terminals are asynchronous pins, and the
  source select, write guard and motor limit come from other words.
*/
module iio_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // parameter access port
  input wire iio_pkg::iio_acc_s acc,
  output logic [15:0] acc_rdata,
  output logic acc_ack,
  output logic acc_err,
  // panel keys and input terminals, asynchronous pins
  input wire iio_pkg::iio_key_s key_pin,
  input wire logic [iio_pkg::N_IN-1:0] term_pin,
  // settings held in other parameter words
  input wire logic [iio_pkg::N_IN-1:0] input_source_select,
  input wire logic special_param_write_guard,
  input wire logic [15:0] motor_max_speed,
  input wire logic [3:0] inch_fwd_input,
  input wire logic [3:0] inch_rev_input,
  // output contacts
  input wire logic [iio_pkg::N_OUT-1:0] drive_out,
  output logic [iio_pkg::N_OUT-1:0] out_contact,
  // combined inputs to the drive
  output logic [iio_pkg::N_IN-1:0] combined_input_state,
  // inching run to the speed loop
  output logic inch_run,
  output logic inch_rev,
  output logic [15:0] inch_speed,
  // calibration
  input wire logic cal_item_done,
  output logic [iio_pkg::N_CAL-1:0] cal_item_start,
  output logic cal_busy
);

  iio_pkg::iio_key_s key_s;
  logic [iio_pkg::N_IN-1:0] term_s;
  logic [15:0] inch_speed_reg;
  logic set_err_reg;
  logic panel_armed_reg;
  logic comm_fwd_reg;
  logic comm_rev_reg;
  logic [iio_pkg::N_OUT-1:0] force_reg;
  logic [iio_pkg::N_IN-1:0] soft_reg;
  logic wr_inch, wr_force, wr_soft, wr_cal;
  logic ok_inch, ok_force, ok_soft, ok_cal;
  logic cal_start;
  logic term_fwd, term_rev, panel_fwd, panel_rev;
  logic want_fwd, want_rev;
  logic [15:0] rd_next;
  logic hit;

  iio_sync #(.W(iio_pkg::N_KEY)) u_key_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(key_pin),
    .q(key_s)
  );

  iio_sync #(.W(iio_pkg::N_IN)) u_term_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(term_pin),
    .q(term_s)
  );

  // write decode and range checks
  assign wr_inch = acc.wr && acc.addr == iio_pkg::OFS_INCH_SPEED;
  assign wr_force = acc.wr && acc.addr == iio_pkg::OFS_FORCE_OUT;
  assign wr_soft = acc.wr && acc.addr == iio_pkg::OFS_IN_STATUS;
  assign wr_cal = acc.wr && acc.addr == iio_pkg::OFS_CAL_SELECT;
  assign ok_inch = acc.wdata <= iio_pkg::INCH_SPEED_MAX;
  assign ok_force = acc.wdata <= iio_pkg::FORCE_MAX;
  assign ok_soft = acc.wdata <= iio_pkg::SOFT_IN_MAX;
  // zero is reserved, busy sequencer cannot take a second code
  assign ok_cal = special_param_write_guard && !cal_busy &&
                  acc.wdata != 16'h0000 && acc.wdata <= iio_pkg::CAL_MAX;
  assign cal_start = wr_cal && ok_cal;

  // inching speed and error state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inch_speed_reg <= iio_pkg::INCH_SPEED_RST;
      set_err_reg <= 1'b0;
    end else if (wr_inch) begin
      if (!ok_inch) begin
        set_err_reg <= 1'b1;
      end else if (acc.from_panel || (acc.wdata != iio_pkg::INCH_FWD_CODE
                   && acc.wdata != iio_pkg::INCH_REV_CODE)) begin
        if (acc.wdata != iio_pkg::INCH_STOP) begin
          inch_speed_reg <= acc.wdata;
          set_err_reg <= 1'b0;
        end
      end
    end
  end

  // run commands latched from the link
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      comm_fwd_reg <= 1'b0;
      comm_rev_reg <= 1'b0;
    end else if (wr_inch && !acc.from_panel && ok_inch) begin
      if (acc.wdata == iio_pkg::INCH_FWD_CODE) begin
        comm_fwd_reg <= 1'b1;
        comm_rev_reg <= 1'b0;
      end else if (acc.wdata == iio_pkg::INCH_REV_CODE) begin
        comm_fwd_reg <= 1'b0;
        comm_rev_reg <= 1'b1;
      end else if (acc.wdata == iio_pkg::INCH_STOP) begin
        comm_fwd_reg <= 1'b0;
        comm_rev_reg <= 1'b0;
      end
    end
  end

  // panel inching mode armed by a speed entry from the panel
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      panel_armed_reg <= 1'b0;
    end else if (wr_inch && ok_inch) begin
      panel_armed_reg <= acc.from_panel &&
                         acc.wdata != iio_pkg::INCH_STOP;
    end
  end

  // run requests; conflicting directions give no run
  assign panel_fwd = panel_armed_reg && key_s.up && !key_s.down;
  assign panel_rev = panel_armed_reg && key_s.down && !key_s.up;
  assign term_fwd = inch_fwd_input != iio_pkg::TERM_NONE &&
    combined_input_state[inch_fwd_input - 4'h1];
  assign term_rev = inch_rev_input != iio_pkg::TERM_NONE &&
    combined_input_state[inch_rev_input - 4'h1];
  assign want_fwd = comm_fwd_reg || term_fwd || panel_fwd;
  assign want_rev = comm_rev_reg || term_rev || panel_rev;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      inch_run <= 1'b0;
      inch_rev <= 1'b0;
      inch_speed <= '0;
    end else begin
      inch_run <= (want_fwd ^ want_rev) && !set_err_reg;
      inch_rev <= want_rev && !want_fwd;
      inch_speed <= (inch_speed_reg > motor_max_speed) ?
                    motor_max_speed : inch_speed_reg;
    end
  end

  // forced outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      force_reg <= '0;
    end else if (wr_force && ok_force) begin
      force_reg <= acc.wdata[iio_pkg::N_OUT-1:0];
    end
  end

  // forcing in effect whenever any force bit is set
  assign out_contact = (force_reg != '0) ? force_reg : drive_out;

  // software input bits
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      soft_reg <= '0;
    end else if (wr_soft && ok_soft) begin
      soft_reg <= acc.wdata[iio_pkg::N_IN-1:0];
    end
  end

  always_comb begin
    for (int i = 0; i < iio_pkg::N_IN; i++) begin
      combined_input_state[i] = input_source_select[i] ?
                                soft_reg[i] : term_s[i];
    end
  end

  iio_cal_seq u_cal (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(cal_start),
    .code(acc.wdata[2:0]),
    .item_done(cal_item_done),
    .item_start(cal_item_start),
    .busy(cal_busy)
  );

  // read mux; same data for panel and link
  always_comb begin
    rd_next = '0;
    hit = 1'b1;
    case (acc.addr)
      iio_pkg::OFS_INCH_SPEED: rd_next = inch_speed_reg;
      iio_pkg::OFS_FORCE_OUT: rd_next[iio_pkg::N_OUT-1:0] = force_reg;
      iio_pkg::OFS_IN_STATUS:
        rd_next[iio_pkg::N_IN-1:0] = combined_input_state;
      iio_pkg::OFS_KEY_CHECK: rd_next[iio_pkg::N_KEY-1:0] = key_s;
      iio_pkg::OFS_OUT_STATUS:
        rd_next[iio_pkg::N_OUT-1:0] = out_contact;
      iio_pkg::OFS_CAL_SELECT: rd_next[2:0] = cal_busy ? 3'h7 : 3'h0;
      default: hit = 1'b0;
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_rdata <= '0;
      acc_ack <= 1'b0;
      acc_err <= 1'b0;
    end else begin
      acc_ack <= acc.wr || acc.rd;
      acc_rdata <= acc.rd ? rd_next : acc_rdata;
      acc_err <= (acc.wr || acc.rd) && (!hit ||
                 (acc.wr && (acc.addr == iio_pkg::OFS_KEY_CHECK ||
                  acc.addr == iio_pkg::OFS_OUT_STATUS)) ||
                 (wr_inch && !ok_inch) || (wr_force && !ok_force) ||
                 (wr_soft && !ok_soft) || (wr_cal && !ok_cal));
    end
  end

  // checks
  sequence s_comm_fwd;
    wr_inch && !acc.from_panel && acc.wdata == iio_pkg::INCH_FWD_CODE;
  endsequence

  sequence s_then_run;
    ##1 comm_fwd_reg
    ##1 (inch_run || $past(set_err_reg) || $past(want_rev));
  endsequence

  a_panel_key_run: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (panel_fwd && !term_rev && !comm_rev_reg && !set_err_reg)
      |=> inch_run && !inch_rev)
    else $error("panel up key did not run forward");

  a_speed_clamp_max: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    inch_speed <= $past(motor_max_speed) || $past(!arst_n))
    else $error("inching speed above motor maximum");

  a_error_no_run: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    set_err_reg |=> !inch_run)
    else $error("inching ran with invalid setting");

  a_term_fwd_run: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (term_fwd && !want_rev && !set_err_reg) |=> inch_run && !inch_rev)
    else $error("terminal forward input did not run");

  a_comm_fwd_start: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    s_comm_fwd |-> s_then_run)
    else $error("link forward code did not start inching");

  a_force_zero_cancel: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_force && acc.wdata == 16'h0000) |=> out_contact == drive_out)
    else $error("writing zero did not cancel forcing");

  a_force_drive_bit: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_force && ok_force && acc.wdata[iio_pkg::N_OUT-1:0] != '0)
      |=> out_contact == $past(acc.wdata[iio_pkg::N_OUT-1:0]))
    else $error("forced bit not on its contact");

  a_in_status_read: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (acc.rd && acc.addr == iio_pkg::OFS_IN_STATUS)
      |=> acc_ack && acc_rdata == 16'($past(combined_input_state)))
    else $error("input status read not combined state");

  a_soft_write_only: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_soft && ok_soft) |=>
      (((combined_input_state ^ term_s) & ~input_source_select) == '0) &&
      (((combined_input_state ^ $past(acc.wdata[iio_pkg::N_IN-1:0])) &
        input_source_select) == '0))
    else $error("soft write disturbed terminal inputs");

  a_cal_guard_refuse: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    (wr_cal && !special_param_write_guard && !cal_busy)
      |=> acc_err ##1 !cal_busy)
    else $error("calibration started without write guard");

endmodule

// File: testbench/iio_cal_model.sv
/*
  Model of the analog calibration side: answers each item start with a
  one-cycle done after a short or a long wait, and records the items.
  Assumes starts are one-cycle pulses on the system clock.
*/
module iio_cal_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // bench control
  input wire logic slow,
  input wire logic clr,
  // calibration handshake
  input wire logic [iio_pkg::N_CAL-1:0] item_start,
  output logic item_done,
  output logic [iio_pkg::N_CAL-1:0] ran,
  output logic [7:0] n_start
);
  logic [3:0] wait_reg;
  logic busy_reg;

  // slow answers keep the sequencer busy long enough to test refusal
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 4'h0;
      busy_reg <= 1'b0;
      item_done <= 1'b0;
    end else begin
      item_done <= 1'b0;
      if (|item_start) begin
        busy_reg <= 1'b1;
        wait_reg <= slow ? 4'h6 : 4'h0;
      end else if (busy_reg && wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        item_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ran <= '0;
      n_start <= 8'h00;
    end else if (clr) begin
      ran <= '0;
      n_start <= 8'h00;
    end else if (|item_start) begin
      ran <= ran | item_start;
      n_start <= n_start + 8'h01;
    end
  end
endmodule

// File: testbench/iio_regs_test.sv
/*
  Self-checking bench for the inching and I/O override words: drives
  the parameter access port, keys, terminals and settings, and checks
  words, contacts, inching outputs and calibration starts.
  Assumes the calibration side model answers every start.
*/
module iio_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  iio_pkg::iio_acc_s acc = '0;
  iio_pkg::iio_key_s key_pin = '0;
  logic [8:0] term_pin = 9'h000;
  logic [8:0] sel = 9'h000;
  logic guard = 1'b0;
  logic [15:0] max_spd = 16'h0bb8;
  logic [3:0] fwd_in = 4'h0;
  logic [3:0] rev_in = 4'h0;
  logic [5:0] drive_out = 6'h2a;
  logic slow = 1'b0;
  logic clr = 1'b0;
  logic [15:0] acc_rdata;
  logic acc_ack, acc_err, inch_run, inch_rev, cal_busy, done;
  logic [5:0] out_contact;
  logic [8:0] comb;
  logic [15:0] inch_speed;
  logic [4:0] cal_start, ran;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;

  iio_regs uut (.clk_sys(clk_sys), .arst_n(arst_n), .acc(acc),
    .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_err(acc_err),
    .key_pin(key_pin), .term_pin(term_pin), .input_source_select(sel),
    .special_param_write_guard(guard), .motor_max_speed(max_spd),
    .inch_fwd_input(fwd_in), .inch_rev_input(rev_in),
    .drive_out(drive_out), .out_contact(out_contact),
    .combined_input_state(comb), .inch_run(inch_run),
    .inch_rev(inch_rev), .inch_speed(inch_speed), .cal_item_done(done),
    .cal_item_start(cal_start), .cal_busy(cal_busy));

  iio_cal_model cal (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow),
    .clr(clr), .item_start(cal_start), .item_done(done), .ran(ran),
    .n_start());

  always #20 clk_sys = ~clk_sys;

  task conclude;
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one request; ack stands one cycle, so look at the next falling edge
  task xfer(input logic w, input logic p, input logic [15:0] a,
            input logic [15:0] d, input logic e, input logic [15:0] x);
    @(negedge clk_sys);
    acc.wr = w;
    acc.rd = !w;
    acc.from_panel = p;
    acc.addr = a;
    acc.wdata = d;
    @(negedge clk_sys);
    chk("ack", {15'h0, acc_ack}, 16'h0001);
    chk("err", {15'h0, acc_err}, {15'h0, e});
    if (!w)
      chk("rdata", acc_rdata, x);
    acc.wr = 1'b0;
    acc.rd = 1'b0;
  endtask

  task run_is(input logic r, input logic v);
    chk("inch_run", {15'h0, inch_run}, {15'h0, r});
    if (r)
      chk("inch_rev", {15'h0, inch_rev}, {15'h0, v});
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    xfer(0, 0, iio_pkg::OFS_IN_STATUS, 16'h0, 0, 16'h0000);
    xfer(1, 0, iio_pkg::OFS_FORCE_OUT, 16'h0005, 0, 16'h0);
    chk("contacts", {10'h0, out_contact}, 16'h0005);
    xfer(0, 1, iio_pkg::OFS_OUT_STATUS, 16'h0, 0, 16'h0005);
    xfer(0, 0, iio_pkg::OFS_OUT_STATUS, 16'h0, 0, 16'h0005);
    xfer(1, 0, iio_pkg::OFS_FORCE_OUT, 16'h0040, 1, 16'h0);
    xfer(1, 0, iio_pkg::OFS_FORCE_OUT, 16'h003f, 0, 16'h0);
    chk("contacts", {10'h0, out_contact}, 16'h003f);
    xfer(1, 0, iio_pkg::OFS_FORCE_OUT, 16'h0000, 0, 16'h0);
    chk("contacts", {10'h0, out_contact}, 16'h002a);
    xfer(1, 0, iio_pkg::OFS_OUT_STATUS, 16'h0001, 1, 16'h0);
    xfer(0, 1, iio_pkg::OFS_OUT_STATUS, 16'h0, 0, 16'h002a);
    // input mix
    sel = 9'h0f0;
    term_pin = 9'h10f;
    xfer(1, 0, iio_pkg::OFS_IN_STATUS, 16'h00a5, 0, 16'h0);
    cyc(3);
    chk("combined", {7'h0, comb}, 16'h01af);
    xfer(0, 0, iio_pkg::OFS_IN_STATUS, 16'h0, 0, 16'h01af);
    term_pin = 9'h000;
    cyc(3);
    xfer(0, 0, iio_pkg::OFS_IN_STATUS, 16'h0, 0, 16'h00a0);
    sel = 9'h1ff;
    xfer(0, 0, iio_pkg::OFS_IN_STATUS, 16'h0, 0, 16'h00a5);
    xfer(1, 0, iio_pkg::OFS_IN_STATUS, 16'h0200, 1, 16'h0);
    xfer(1, 0, iio_pkg::OFS_IN_STATUS, 16'h01ff, 0, 16'h0);
    xfer(0, 0, iio_pkg::OFS_IN_STATUS, 16'h0, 0, 16'h01ff);
    sel = 9'h000;
    // keys pass two sync flops
    key_pin = 5'h15;
    cyc(4);
    xfer(0, 1, iio_pkg::OFS_KEY_CHECK, 16'h0, 0, 16'h0015);
    key_pin = 5'h0a;
    cyc(4);
    xfer(0, 0, iio_pkg::OFS_KEY_CHECK, 16'h0, 0, 16'h000a);
    key_pin = 5'h00;
    xfer(1, 0, iio_pkg::OFS_KEY_CHECK, 16'h0001, 1, 16'h0);
    // link inching
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd100, 0, 16'h0);
    cyc(2);
    chk("speed", inch_speed, 16'd100);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd4998, 0, 16'h0);
    cyc(1);
    run_is(1, 0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd4999, 0, 16'h0);
    cyc(1);
    run_is(1, 1);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd0, 0, 16'h0);
    cyc(1);
    run_is(0, 0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd5000, 0, 16'h0);
    cyc(2);
    chk("speed", inch_speed, 16'd3000);
    max_spd = 16'd6000;
    cyc(2);
    chk("speed", inch_speed, 16'd5000);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd5001, 1, 16'h0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd4998, 0, 16'h0);
    cyc(1);
    run_is(0, 0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd100, 0, 16'h0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd4998, 0, 16'h0);
    cyc(1);
    run_is(1, 0);
    xfer(1, 0, iio_pkg::OFS_INCH_SPEED, 16'd0, 0, 16'h0);
    // panel keys
    xfer(1, 1, iio_pkg::OFS_INCH_SPEED, 16'd50, 0, 16'h0);
    key_pin = 5'h02;
    cyc(4);
    run_is(1, 0);
    key_pin = 5'h04;
    cyc(4);
    run_is(1, 1);
    key_pin = 5'h00;
    cyc(4);
    run_is(0, 0);
    xfer(1, 1, iio_pkg::OFS_INCH_SPEED, 16'd0, 0, 16'h0);
    // assigned terminals
    fwd_in = 4'h3;
    rev_in = 4'h4;
    term_pin = 9'h004;
    cyc(4);
    run_is(1, 0);
    term_pin = 9'h008;
    cyc(4);
    run_is(1, 1);
    term_pin = 9'h000;
    cyc(4);
    run_is(0, 0);
    // calibration, refused without the write guard, then each code, odd codes with slow answers and even codes with fast ones
    xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'h0001, 1, 16'h0);
    cyc(3);
    chk("cal ran", {11'h0, ran}, 16'h0000);
    guard = 1'b1;
    for (i = 1; i <= 6; i++) begin
      clr = 1'b1;
      slow = i[0];
      cyc(1);
      clr = 1'b0;
      xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'(i), 0, 16'h0);
      for (int k = 0; k < 200 && cal_busy !== 1'b0; k++)
        cyc(1);
      chk("cal ran", {11'h0, ran}, (i == 5) ? 16'h000f : (i == 6) ?
          16'h0010 : 16'h0001 << (i - 1));
    end
    xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'h0005, 0, 16'h0);
    xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'h0001, 1, 16'h0);
    cyc(60);
    xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'h0000, 1, 16'h0);
    xfer(1, 0, iio_pkg::OFS_CAL_SELECT, 16'h0007, 1, 16'h0);
    xfer(0, 0, 16'h0500, 16'h0, 1, 16'h0000);
    conclude();
  end
endmodule
